// file: design/stc_params.svh
// Purpose: constants for the switch table command register bank
// Assumes: APB byte addresses are four times the register index
// Notes:   times in their own units, cycle counts derived from the clock rate
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH
`define STC_IDX_ADDR_STS     14'h1808
`define STC_IDX_ADDR_CFG     14'h1809
`define STC_IDX_VLAN_CMD     14'h180b
`define STC_IDX_VLAN_WDATA   14'h180c
`define STC_IDX_VLAN_CMD_STS 14'h180d
`define STC_IDX_VLAN_RDATA   14'h180e
`define STC_IDX_AGE_TICK     14'h1810
`define STC_CLK_MHZ          100
`define STC_INIT_US          20
`define STC_INIT_CYCLES      (`STC_INIT_US * `STC_CLK_MHZ)
`define STC_AGE_NORMAL_S     300
`define STC_AGE_TEST_MS      50
`define STC_AGE_NORMAL_CYC   (64'(`STC_AGE_NORMAL_S) * 64'(1000000) * 64'(`STC_CLK_MHZ))
`define STC_AGE_TEST_CYC     (64'(`STC_AGE_TEST_MS) * 64'(1000) * 64'(`STC_CLK_MHZ))
`define STC_ACCESS_CYCLES    2
`define STC_BIT_INIT_DONE    1
`define STC_BIT_MAKE_PEND    0
`define STC_BIT_AGE_TEST     0
`define STC_BIT_RNW          5
`define STC_BIT_PORT_SEL     4
`define STC_BIT_PENDING      0
`define STC_PVID_LSB         0
`define STC_PVID_MSB         11
`define STC_PRIO_LSB         12
`define STC_PRIO_MSB         14
`define STC_VID_MSB          11
`define STC_UNTAG0_BIT       12
`define STC_MEMBER0_BIT      13
`define STC_ENTRY_MSB        17
`define STC_CMD_MSB          5
`endif

// file: design/stc_pkg.sv
// Purpose: types for the switch table command register bank
// Assumes: nothing beyond the params header
// Notes:   states are one-hot
package stc_pkg;
  typedef enum logic [2:0] {
    STC_INIT   = 3'b001,
    STC_IDLE   = 3'b010,
    STC_ACCESS = 3'b100
  } stc_state_type;
  typedef logic [17:0] stc_entry_type;
endpackage : stc_pkg

// file: design/stc_age_timer.sv
// Purpose: address table aging period timer
// Assumes: one clock, ticks issued as one-cycle enable pulses
// Notes:   test mode shortens the period; a mode change restarts the count
`timescale 1ns/1ns
`include "stc_params.svh"
module stc_age_timer #(
  parameter logic [63:0] NORMAL_CYCLES = `STC_AGE_NORMAL_CYC,
  parameter logic [63:0] TEST_CYCLES   = `STC_AGE_TEST_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // control
  input  wire logic ageTest,
  input  wire logic run,
  // event
  output logic      ageTick
);
  import stc_pkg::*;
  logic [63:0] count;
  logic [63:0] next_count;
  logic        lastTest;
  logic        next_ageTick;
  logic [63:0] period;

  always_comb
  begin
    period       = ageTest ? TEST_CYCLES : NORMAL_CYCLES;
    next_count   = count;
    next_ageTick = 1'b0;
    if (!run || (ageTest != lastTest))
    begin
      next_count = 64'h0;
    end
    else if (count >= period - 64'h1)
    begin
      next_count   = 64'h0;
      next_ageTick = 1'b1;
    end
    else
    begin
      next_count = count + 64'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count    <= 64'h0;
      lastTest <= 1'b0;
      ageTick  <= 1'b0;
    end
    else
    begin
      count    <= next_count;
      lastTest <= ageTest;
      ageTick  <= next_ageTick;
    end
  end
endmodule : stc_age_timer

// file: design/stc_switch_table_regs.sv
// Purpose: APB register bank for address table status/config and VLAN/port default tables
// Assumes: APB with 32-bit data, byte address = register index * 4
// Notes:   entry creation is requested by the lookup engine on makeStart/makeDone
//
// Functional notes
// (RULE1) init-done reads 0, sets after init
// (RULE2) init about 20 us, drop packets meanwhile
// (RULE3) software polls init-done before table writes
// (RULE4) make-pending high during entry creation
// (RULE5) age test shortens aging to 50 ms
// (RULE6) command write launches the table access
// (RULE7) read result appears in read-data register
// (RULE8) software loads write data before write command
// (RULE9) command bit 5 selects read or write
// (RULE10) command bit 4 selects port table
// (RULE11) index VLAN 0-15 or port 0-2
// (RULE12) port entry: VID 11:0, priority 14:12
// (RULE13) port defaults apply to untagged/null packets
// (RULE14) port defaults reset to zero
// (RULE15) software avoids VID zero and all ones
// (RULE16) VLAN entry bit 17 is port 2 member
// (RULE17) membership admits ingress, non-member filtered
// (RULE18) bits 16/14/12 untag, 15/13 member
// (RULE19) VLAN entry VID 11:0, zero disables
// (RULE20) pending held until access completes
`timescale 1ns/1ns
`include "stc_params.svh"
module stc_switch_table_regs #(
  parameter int          VLAN_ENTRIES = 16,
  parameter int          PORTS        = 3,
  parameter int unsigned INIT_CYCLES  = `STC_INIT_CYCLES,
  parameter logic [63:0] AGE_NORMAL   = `STC_AGE_NORMAL_CYC,
  parameter logic [63:0] AGE_TEST     = `STC_AGE_TEST_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // entry creation from the learning engine
  input  wire logic        makeStart,
  input  wire logic        makeDone,
  // aging
  output logic             ageTick,
  // ingress classification
  input  wire logic [1:0]  rxPort,
  input  wire logic        rxTagged,
  input  wire logic [11:0] rxVid,
  input  wire logic [2:0]  rxPrio,
  input  wire logic [1:0]  rxAdmitNonMember,
  output logic [11:0]      effVid,
  output logic [2:0]       effPrio,
  output logic             rxAdmit,
  output logic             rxDrop,
  output logic [2:0]       egressMembers,
  output logic [2:0]       egressUntag
);
  import stc_pkg::*;

  stc_state_type state;
  stc_state_type next_state;
  logic [31:0]   initCount;
  logic [31:0]   next_initCount;
  logic [31:0]   accCount;
  logic [31:0]   next_accCount;
  logic          initDone;
  logic          next_initDone;
  logic          makePending;
  logic          next_makePending;
  logic          ageTest;
  logic          next_ageTest;
  logic [5:0]    cmd;
  logic [5:0]    next_cmd;
  stc_entry_type wrData;
  stc_entry_type next_wrData;
  stc_entry_type rdData;
  stc_entry_type next_rdData;
  stc_entry_type vlanTable [VLAN_ENTRIES];
  stc_entry_type portTable [PORTS];
  logic          wrStrobe;
  logic          rdStrobe;
  logic [13:0]   regIndex;
  logic          mapped;
  logic [31:0]   readMux;
  logic [3:0]    idx;

  function automatic logic isIndex(input logic [13:0] a, input logic [13:0] r);
    isIndex = (a == r);
  endfunction : isIndex

  assign regIndex = paddr[15:2];
  assign wrStrobe = psel && penable && pwrite;
  assign rdStrobe = psel && penable && !pwrite;
  assign pready   = 1'b1;
  assign mapped   = isIndex(regIndex, `STC_IDX_ADDR_STS) || isIndex(regIndex, `STC_IDX_ADDR_CFG)
                 || isIndex(regIndex, `STC_IDX_VLAN_CMD) || isIndex(regIndex, `STC_IDX_VLAN_WDATA)
                 || isIndex(regIndex, `STC_IDX_VLAN_CMD_STS)
                 || isIndex(regIndex, `STC_IDX_VLAN_RDATA);
  assign pslverr  = psel && penable && !mapped;
  // (RULE11) entry or port index
  assign idx      = cmd[3:0];

  // control state next values
  always_comb
  begin
    next_state       = state;
    next_initCount   = initCount;
    next_accCount    = accCount;
    next_initDone    = initDone;
    next_makePending = makePending;
    next_ageTest     = ageTest;
    next_cmd         = cmd;
    next_wrData      = wrData;
    next_rdData      = rdData;
    // (RULE4) make pending flag
    if (makeStart)
    begin
      next_makePending = 1'b1;
    end
    else if (makeDone)
    begin
      next_makePending = 1'b0;
    end
    if (wrStrobe && isIndex(regIndex, `STC_IDX_ADDR_CFG))
    begin
      next_ageTest = pwdata[`STC_BIT_AGE_TEST];
    end
    if (wrStrobe && isIndex(regIndex, `STC_IDX_VLAN_WDATA))
    begin
      next_wrData = pwdata[`STC_ENTRY_MSB:0];
    end
    unique case (state)
      STC_INIT:
      begin
        // (RULE1) init-done sets at count end
        if (initCount >= INIT_CYCLES - 1)
        begin
          next_initDone = 1'b1;
          next_state    = STC_IDLE;
        end
        else
        begin
          next_initCount = initCount + 32'h1;
        end
      end
      STC_IDLE:
      begin
        // (RULE6) command write launches access
        if (wrStrobe && isIndex(regIndex, `STC_IDX_VLAN_CMD))
        begin
          next_cmd      = pwdata[`STC_CMD_MSB:0];
          next_accCount = 32'h0;
          next_state    = STC_ACCESS;
        end
      end
      STC_ACCESS:
      begin
        // (RULE20) pending until access finishes
        if (accCount >= `STC_ACCESS_CYCLES - 1)
        begin
          next_state = STC_IDLE;
          // (RULE7) capture read result
          if (cmd[`STC_BIT_RNW])
          begin
            next_rdData = cmd[`STC_BIT_PORT_SEL] ? portTable[idx[1:0]] : vlanTable[idx];
          end
        end
        else
        begin
          next_accCount = accCount + 32'h1;
        end
      end
      default:
      begin
        next_state = STC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state       <= STC_INIT;
      initCount   <= 32'h0;
      accCount    <= 32'h0;
      initDone    <= 1'b0;
      makePending <= 1'b0;
      ageTest     <= 1'b0;
      cmd         <= 6'h0;
      wrData      <= 18'h0;
      rdData      <= 18'h0;
    end
    else
    begin
      state       <= next_state;
      initCount   <= next_initCount;
      accCount    <= next_accCount;
      initDone    <= next_initDone;
      makePending <= next_makePending;
      ageTest     <= next_ageTest;
      cmd         <= next_cmd;
      wrData      <= next_wrData;
      rdData      <= next_rdData;
    end
  end

  // table storage, written at the end of a write access
  generate
    for (genvar v = 0; v < VLAN_ENTRIES; v++)
    begin : g_vlan
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          vlanTable[v] <= 18'h0;
        end
        // (RULE10) table select and (RULE9) direction
        else if (state == STC_ACCESS && next_state == STC_IDLE && !cmd[`STC_BIT_RNW]
                 && !cmd[`STC_BIT_PORT_SEL] && idx == 4'(v))
        begin
          vlanTable[v] <= wrData;
        end
      end
    end
    for (genvar p = 0; p < PORTS; p++)
    begin : g_port
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        // (RULE14) port defaults reset to zero
        if (!rst_b)
        begin
          portTable[p] <= 18'h0;
        end
        // (RULE12) only VID and priority kept
        else if (state == STC_ACCESS && next_state == STC_IDLE && !cmd[`STC_BIT_RNW]
                 && cmd[`STC_BIT_PORT_SEL] && idx == 4'(p))
        begin
          portTable[p] <= {3'h0, wrData[`STC_PRIO_MSB:`STC_PVID_LSB]};
        end
      end
    end
  endgenerate

  // register read mux
  always_comb
  begin
    readMux = 32'h0;
    if (isIndex(regIndex, `STC_IDX_ADDR_STS))
    begin
      readMux[`STC_BIT_INIT_DONE] = initDone;
      readMux[`STC_BIT_MAKE_PEND] = makePending;
    end
    else if (isIndex(regIndex, `STC_IDX_ADDR_CFG))
    begin
      readMux[`STC_BIT_AGE_TEST] = ageTest;
    end
    else if (isIndex(regIndex, `STC_IDX_VLAN_CMD))
    begin
      readMux[`STC_CMD_MSB:0] = cmd;
    end
    else if (isIndex(regIndex, `STC_IDX_VLAN_WDATA))
    begin
      readMux[`STC_ENTRY_MSB:0] = wrData;
    end
    else if (isIndex(regIndex, `STC_IDX_VLAN_CMD_STS))
    begin
      readMux[`STC_BIT_PENDING] = (state == STC_ACCESS);
    end
    else if (isIndex(regIndex, `STC_IDX_VLAN_RDATA))
    begin
      readMux[`STC_ENTRY_MSB:0] = rdData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h0;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= readMux;
    end
  end

  // (RULE5) aging period selection
  stc_age_timer #(
    .NORMAL_CYCLES (AGE_NORMAL),
    .TEST_CYCLES   (AGE_TEST)
  ) u_age (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .ageTest  (ageTest),
    .run      (initDone),
    .ageTick  (ageTick)
  );

  // ingress classification against the tables
  always_comb
  begin
    logic          useDefault;
    logic          hit;
    stc_entry_type pent;
    stc_entry_type vent;
    useDefault    = 1'b0;
    hit           = 1'b0;
    pent          = portTable[(rxPort < 2'(PORTS)) ? rxPort : 2'h0];
    vent          = 18'h0;
    // (RULE13) untagged or null VID uses port defaults
    useDefault    = !rxTagged || (rxVid == 12'h0);
    effVid        = useDefault ? pent[`STC_PVID_MSB:`STC_PVID_LSB] : rxVid;
    effPrio       = useDefault ? pent[`STC_PRIO_MSB:`STC_PRIO_LSB] : rxPrio;
    for (int i = 0; i < VLAN_ENTRIES; i++)
    begin
      // (RULE19) zero VID disables entry
      if (!hit && vlanTable[i][`STC_VID_MSB:0] != 12'h0
          && vlanTable[i][`STC_VID_MSB:0] == effVid)
      begin
        hit  = 1'b1;
        vent = vlanTable[i];
      end
    end
    // (RULE18) member and untag bit pairs, (RULE16) port 2 at top
    for (int k = 0; k < 3; k++)
    begin
      egressMembers[k] = vent[`STC_MEMBER0_BIT + 2 * k];
      egressUntag[k]   = vent[`STC_UNTAG0_BIT + 2 * k];
    end
    // (RULE17) member admits, else non-member admission
    rxAdmit = initDone && hit && (egressMembers[rxPort] || rxAdmitNonMember[rxPort[0]]);
    // (RULE2) drop while table initializing
    rxDrop  = !initDone;
  end
endmodule : stc_switch_table_regs

// file: tb/stc_regs_assertions.sv
// Purpose: port checks for the switch table register bank
// Assumes: byte address = index * 4, prdata loaded at the setup edge
// Notes:   two cycles of margin on init timing
`timescale 1ns/1ns
module stc_regs_assertions #(
  parameter int unsigned INIT_CYCLES = 2000
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  // engine and ingress
  input wire logic        makeStart,
  input wire logic        makeDone,
  input wire logic        ageTick,
  input wire logic [1:0]  rxPort,
  input wire logic        rxTagged,
  input wire logic [11:0] rxVid,
  input wire logic [11:0] effVid,
  input wire logic [2:0]  effPrio,
  input wire logic        rxDrop
);
  logic [31:0] cyc;
  logic [31:0] next_cyc;
  logic        mk;
  logic        next_mk;
  logic        cmdSeen;
  logic        next_cmdSeen;
  logic        rdSts;
  logic        rdPend;
  logic        cmdWr;
  assign rdSts  = psel & ~penable & ~pwrite & (paddr == 16'h6020);
  assign rdPend = psel & ~penable & ~pwrite & (paddr == 16'h6034);
  assign cmdWr  = psel & penable & pwrite & (paddr == 16'h602c);
  always_comb
  begin
    next_cyc     = (cyc == 32'hffffffff) ? cyc : cyc + 32'h1;
    next_mk      = makeStart | (mk & ~makeDone);
    next_cmdSeen = cmdSeen | cmdWr;
  end
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cyc     <= 32'h0;
      mk      <= 1'b0;
      cmdSeen <= 1'b0;
    end
    else
    begin
      cyc     <= next_cyc;
      mk      <= next_mk;
      cmdSeen <= next_cmdSeen;
    end
  end
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  init_drop_a:
    assert property (cyc < INIT_CYCLES - 1 |-> rxDrop)
    else $error("packet not dropped during init");
  init_low_a:
    assert property (rdSts && cyc < INIT_CYCLES - 2 |=> !prdata[1])
    else $error("init done too early");
  init_set_a:
    assert property (rdSts && cyc > INIT_CYCLES + 2 |=> prdata[1])
    else $error("init done missing");
  make_flag_a:
    assert property (rdSts |=> prdata[0] == $past(mk))
    else $error("make pending flag wrong");
  pend_set_a:
    assert property (cmdWr && cyc > INIT_CYCLES + 2 ##2 rdPend |=> prdata[0])
    else $error("pending not shown after command");
  tag_keep_a:
    assert property (rxTagged && rxVid != 12'h000 |-> effVid == rxVid)
    else $error("tagged vid not kept");
  dflt_zero_a:
    assert property (!cmdSeen && !rxTagged && rxPort != 2'h3 |-> {effPrio, effVid} == 15'h0)
    else $error("port default not zero");
  age_pulse_a:
    assert property (ageTick |=> !ageTick)
    else $error("age tick longer than one cycle");
  cover property (rdSts && cyc > INIT_CYCLES + 2);
  cover property (cmdWr ##2 rdPend);
  cover property (ageTick);
endmodule : stc_regs_assertions

// file: tb/tb_switch_table_command_regs.sv
// Purpose: bench for the switch table register bank
// Assumes: zero-wait APB, byte address = index * 4
// Notes:   short init and aging counts
`timescale 1ns/1ns
module tb_switch_table_command_regs;
  localparam logic [63:0] AGEN = 100;
  localparam logic [63:0] AGET = 10;
  localparam logic [15:0] RA [3] = '{16'h6024, 16'h602c, 16'h6030};
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic        makeStart = 1'b0;
  logic        makeDone = 1'b0;
  logic [1:0]  rxPort = '0;
  logic        rxTagged = 1'b0;
  logic [11:0] rxVid = '0;
  logic [2:0]  rxPrio = 3'h5;
  logic [1:0]  rxAdm = '0;
  logic        pready, pslverr, ageTick, rxAdmit, rxDrop, e;
  logic [31:0] prdata, q;
  logic [11:0] effVid;
  logic [2:0]  effPrio, egM, egU;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          tick = 0;
  int          g;
  stc_switch_table_regs #(.INIT_CYCLES(20), .AGE_NORMAL(AGEN), .AGE_TEST(AGET)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .makeStart(makeStart), .makeDone(makeDone), .ageTick(ageTick), .rxPort(rxPort),
    .rxTagged(rxTagged), .rxVid(rxVid), .rxPrio(rxPrio), .rxAdmitNonMember(rxAdm),
    .effVid(effVid), .effPrio(effPrio), .rxAdmit(rxAdmit), .rxDrop(rxDrop),
    .egressMembers(egM), .egressUntag(egU));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    tick++;
    if (tick == 3000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
    cmp_count++;
    if (y !== x)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, x, y);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // command is written, then pending is polled until the access completes
  task automatic tab(input logic [5:0] c, input logic [31:0] d);
    if (!c[5])
      xfer(1'b1, 16'h6030, d);
    xfer(1'b1, 16'h602c, {26'h0, c});
    xfer(1'b0, 16'h6034, 0);
    for (int n = 0; n < 20 && q[0] !== 1'b0; n++)
      xfer(1'b0, 16'h6034, 0);
    chk("pend", 0, 32'(q[0]));
    if (c[5])
      xfer(1'b0, 16'h6038, 0);
  endtask : tab
  task automatic rx(input logic [1:0] p, input logic t, input logic [11:0] v);
    @(posedge core_clk);
    rxPort <= p;
    rxTagged <= t;
    rxVid <= v;
    #1;
  endtask : rx
  task automatic pulse(input logic s);
    @(posedge core_clk);
    makeStart <= s;
    makeDone <= !s;
    @(posedge core_clk);
    makeStart <= 1'b0;
    makeDone <= 1'b0;
    xfer(1'b0, 16'h6020, 0);
  endtask : pulse
  task automatic ageGap(output int n);
    for (int k = 0; k < 300 && ageTick !== 1'b1; k++)
      @(posedge core_clk);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ageTick !== 1'b1 && n < 300);
  endtask : ageGap
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    chk("drop", 1, 32'(rxDrop));
    xfer(1'b0, 16'h6020, 0);
    chk("sts", 0, q);
    for (int n = 0; n < 40 && q[1] !== 1'b1; n++)
      xfer(1'b0, 16'h6020, 0);
    chk("sts", 2, q);
    chk("drop", 0, 32'(rxDrop));
    foreach (RA[i])
    begin
      xfer(1'b0, RA[i], 0);
      chk("rst", 0, q);
    end
    xfer(1'b0, 16'h6028, 0);
    chk("unmap", 1, 32'(e));
    for (int p = 0; p < 3; p++)
    begin
      rx(2'(p), 1'b0, 0);
      chk("pvid", 0, {effPrio, effVid});
      tab(6'h10 + 6'(p), 32'h39100 + 32'(p * 'h1001));
      tab(6'h30 + 6'(p), 0);
      chk("prd", 32'h1100 + 32'(p * 'h1001), q);
      for (int t = 0; t < 2; t++)
      begin
        rx(2'(p), t[0], 0);
        chk("dflt", 32'h1100 + 32'(p * 'h1001), {effPrio, effVid});
      end
    end
    tab(6'h0f, 32'hfffe6123);
    tab(6'h00, 32'hfffda555);
    tab(6'h2f, 0);
    chk("vrd", 32'h26123, q);
    tab(6'h20, 0);
    chk("vrd", 32'h1a555, q);
    rx(2'd0, 1'b1, 12'h123);
    chk("eg", 32'h55, {egM, egU, rxAdmit});
    chk("prio", 5, 32'(effPrio));
    rx(2'd1, 1'b1, 12'h123);
    chk("eg", 32'h54, {egM, egU, rxAdmit});
    @(posedge core_clk);
    rxAdm <= 2'b10;
    rx(2'd1, 1'b1, 12'h123);
    chk("eg", 32'h55, {egM, egU, rxAdmit});
    rx(2'd1, 1'b1, 12'h555);
    chk("eg", 32'h39, {egM, egU, rxAdmit});
    pulse(1'b1);
    chk("mk", 3, q);
    pulse(1'b0);
    chk("mk", 2, q);
    xfer(1'b1, 16'h6024, 32'hffffffff);
    xfer(1'b0, 16'h6024, 0);
    chk("cfg", 1, q);
    repeat (2) ageGap(g);
    chk("age", AGET[31:0], 32'(g));
    xfer(1'b1, 16'h6024, 0);
    repeat (2) ageGap(g);
    chk("age", AGEN[31:0], 32'(g));
    tally_and_finish();
  end
endmodule : tb_switch_table_command_regs
bind stc_switch_table_regs stc_regs_assertions #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .makeStart(makeStart), .makeDone(makeDone),
  .ageTick(ageTick), .rxPort(rxPort), .rxTagged(rxTagged), .rxVid(rxVid),
  .effVid(effVid), .effPrio(effPrio), .rxDrop(rxDrop));
